// File: include/adsrp_pkg.sv
// Constants and types shared by the serial result port
package adsrp_pkg;

    localparam int FRAME_BITS = 32;
    localparam int CFG_BITS = 13;
    localparam logic [5:0] FRAME_LAST = 6'h20;
    localparam logic [5:0] CFG_LAST = 6'h0c;
    localparam logic [2:0] PREFIX_LOAD = 3'h5;
    localparam int EN2_POS = 4;
    localparam int SYS_CLK_NS = 4;
    localparam int SCK_HALF_NS = 80;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [4:0] SEL_RESET = 5'h00;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic signed [31:0] CODE_OVER = 32'sh1000_0000;
    localparam logic signed [31:0] CODE_UNDER = -32'sh1000_0001;

    typedef struct packed {
        logic eoc_n;
        logic filler_bit;
        logic sign_flag;
        logic [23:0] result;
        logic [4:0] sub_lsb;
    } adsrp_frame_t;

    typedef struct packed {
        logic [4:0] sel;
        logic [3:0] mode;
    } adsrp_cfg_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
    } adsrp_pins_t;

endpackage

// File: hdl/adsrp_pin_sync.sv
// Two-stage pin synchroniser with edge pulses
`timescale 1ns/1ps
module adsrp_pin_sync
    import adsrp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Raw pins
    input adsrp_pins_t pin_raw,
    // Synchronised levels and edges
    output adsrp_pins_t pin_q,
    output adsrp_pins_t pin_rise,
    output adsrp_pins_t pin_fall
);
    adsrp_pins_t meta;
    adsrp_pins_t prev;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 3'h7;
            pin_q <= 3'h7;
            prev <= 3'h7;
        end
        else
        begin
            meta <= pin_raw;
            pin_q <= meta;
            prev <= pin_q;
        end
    end

    assign pin_rise = pin_q & ~prev;
    assign pin_fall = ~pin_q & prev;
endmodule

// File: hdl/adsrp_result_fmt.sv
// Clamps a raw sample and builds the 32-bit output frame
`timescale 1ns/1ps
module adsrp_result_fmt
    import adsrp_pkg::*;
(
    // Raw sample in sub-LSB units
    input wire logic signed [31:0] sample,
    // Formatted frame
    output adsrp_frame_t frame
);
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v);
        if (v > CODE_OVER)
            clamp = CODE_OVER;
        else if (v < CODE_UNDER)
            clamp = CODE_UNDER;
        else
            clamp = v;
    endfunction

    logic signed [31:0] c;

    always_comb
    begin
        c = clamp(sample);
        frame.eoc_n = 1'b0;
        frame.filler_bit = 1'b0;
        frame.sign_flag = ~c[31];
        frame.result = c[28:5];
        frame.sub_lsb = c[4:0];
    end
endmodule

// File: hdl/adsrp_serial_port.sv
// Serial result port: conversion timing, frame output, setup input
`timescale 1ns/1ps
module adsrp_serial_port
    import adsrp_pkg::*;
#(
    parameter int CONV_CYCLES = 40000
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // Converter side
    input wire logic signed [31:0] conv_sample,
    output logic conv_busy,
    output logic sck_master,
    output adsrp_cfg_t active_cfg
);
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] CONV_LOAD = CW'(CONV_CYCLES - 1);
    localparam int HW = $clog2(SCK_HALF_CYC + 1);
    localparam logic [HW-1:0] HALF_LOAD = HW'(SCK_HALF_CYC - 1);

    typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_SHIFT} adsrp_state_t;

    // Last rising edge of a frame reached
    function automatic logic at_frame_end(input logic [5:0] n);
        return n == FRAME_LAST;
    endfunction

    // Leading bits that ask for a new setup
    function automatic logic is_load(input logic [CFG_BITS-1:0] w);
        return w[12:10] == PREFIX_LOAD;
    endfunction

    // Clock edge source chosen by the strap
    function automatic logic pick_edge(input logic master, input logic gen, input logic pin);
        return master ? gen : pin;
    endfunction

    adsrp_pins_t pin_q;
    adsrp_pins_t pin_rise;
    adsrp_pins_t pin_fall;
    adsrp_frame_t fmt_frame;
    adsrp_frame_t frame_q;
    adsrp_state_t state;
    adsrp_cfg_t pend_cfg;
    logic pend_sel;
    logic pend_mode;
    logic [CW-1:0] conv_cnt;
    logic [HW-1:0] half_cnt;
    logic [5:0] rise_cnt;
    logic [31:0] shreg;
    logic [11:0] cfg_sh;
    logic [CFG_BITS-1:0] cfg_word;
    logic mode_armed;
    logic selected;
    logic conv_done;
    logic half_tick;
    logic gen_rise;
    logic gen_fall;
    logic rise_ev;
    logic fall_ev;
    logic end_frame;
    logic abort_frame;
    logic to_sleep;
    logic start_conv;
    logic shifting;
    logic gen_run;

    adsrp_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_raw({cs_n, sck_in, sdi}),
        .pin_q(pin_q),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall)
    );

    adsrp_result_fmt u_fmt (
        .sample(conv_sample),
        .frame(fmt_frame)
    );

    // Event decode
    assign selected = ~pin_q.cs_n;
    assign shifting = (state == ST_SHIFT);
    assign gen_run = sck_master && selected && shifting;
    assign conv_done = (state == ST_CONV) && (conv_cnt == '0);
    assign half_tick = (half_cnt == '0);
    assign gen_rise = half_tick && !sck_out && !at_frame_end(rise_cnt);
    assign gen_fall = half_tick && sck_out;
    assign rise_ev = shifting && selected &&
        pick_edge(sck_master, gen_rise, pin_rise.sck);
    assign fall_ev = shifting && selected &&
        pick_edge(sck_master, gen_fall, pin_fall.sck);
    assign end_frame = fall_ev && at_frame_end(rise_cnt);
    assign abort_frame = shifting && pin_rise.cs_n && (rise_cnt != '0);
    assign to_sleep = shifting && pin_rise.cs_n && (rise_cnt == '0);
    assign start_conv = end_frame || abort_frame;
    assign cfg_word = {cfg_sh, pin_q.sdi};
    assign conv_busy = (state == ST_CONV);

    // Strap window open for the first cycle after reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_armed <= 1'b1;
        else
            mode_armed <= 1'b0;
    end

    // Clock mode strap, caught after reset release and at each select
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sck_master <= 1'b1;
        else if (mode_armed || pin_fall.cs_n)
            sck_master <= pin_q.sck;
    end

    // Main sequence
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_CONV;
        else
        begin
            unique case (state)
                ST_CONV:
                begin
                    if (conv_done)
                        state <= selected ? ST_SHIFT : ST_SLEEP;
                end
                ST_SLEEP:
                begin
                    if (pin_fall.cs_n)
                        state <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    if (start_conv)
                        state <= ST_CONV;
                    else if (to_sleep)
                        state <= ST_SLEEP;
                end
            endcase
        end
    end

    // Conversion timer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_cnt <= CONV_LOAD;
        else if (start_conv)
            conv_cnt <= CONV_LOAD;
        else if ((state == ST_CONV) && !conv_done)
            conv_cnt <= conv_cnt - 1'b1;
    end

    // Result capture at completion
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            frame_q <= '0;
        else if (conv_done)
            frame_q <= fmt_frame;
    end

    // Rising edge count within a frame
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rise_cnt <= '0;
        else if (state != ST_SHIFT)
            rise_cnt <= '0;
        else if (rise_ev && !at_frame_end(rise_cnt))
            rise_cnt <= rise_cnt + 6'h01;
    end

    // Output shifter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            shreg <= '0;
        else if (state != ST_SHIFT)
            shreg <= conv_done ? fmt_frame : frame_q;
        else if (fall_ev && (rise_cnt != '0) && !at_frame_end(rise_cnt))
            shreg <= {shreg[30:0], 1'b1};
    end

    // Data output enable follows select
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sdo_oe <= 1'b0;
        else
            sdo_oe <= selected;
    end

    // Data output level
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sdo_out <= 1'b1;
        else if (!selected)
            sdo_out <= 1'b1;
        else if (conv_done)
            sdo_out <= 1'b0;
        else if (state == ST_CONV || end_frame)
            sdo_out <= 1'b1;
        else if (shifting)
            sdo_out <= shreg[31];
        else
            sdo_out <= 1'b0;
    end

    // Internal clock half period timer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            half_cnt <= HALF_LOAD;
        else if (!gen_run || half_tick)
            half_cnt <= HALF_LOAD;
        else
            half_cnt <= half_cnt - 1'b1;
    end

    // Internal clock level, low outside frames
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sck_out <= 1'b0;
        else if (!gen_run)
            sck_out <= 1'b0;
        else if (gen_rise)
            sck_out <= 1'b1;
        else if (gen_fall)
            sck_out <= 1'b0;
    end

    // Clock pin driven only as master while selected
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sck_oe <= 1'b0;
        else
            sck_oe <= sck_master && selected && !pin_fall.cs_n;
    end

    // Setup input shifter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_sh <= '0;
        else if (state != ST_SHIFT)
            cfg_sh <= '0;
        else if (rise_ev && (rise_cnt < CFG_LAST))
            cfg_sh <= cfg_word[11:0];
    end

    // Pending setup enables, decoded on the thirteenth rising edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_sel <= 1'b0;
            pend_mode <= 1'b0;
        end
        else if (!shifting)
        begin
            pend_sel <= 1'b0;
            pend_mode <= 1'b0;
        end
        else if (rise_ev && (rise_cnt == CFG_LAST))
        begin
            pend_sel <= is_load(cfg_word);
            pend_mode <= is_load(cfg_word) && cfg_word[EN2_POS];
        end
    end

    // Pending setup fields, taken on the same edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_cfg <= '0;
        else if (rise_ev && (rise_cnt == CFG_LAST))
            pend_cfg <= {cfg_word[9:5], cfg_word[3:0]};
    end

    // Setup takes effect when the next conversion starts
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            active_cfg <= {SEL_RESET, MODE_RESET};
        else if (start_conv)
        begin
            if (pend_sel)
                active_cfg.sel <= pend_cfg.sel;
            if (pend_mode)
                active_cfg.mode <= pend_cfg.mode;
        end
    end
endmodule

// File: tb/adsrp_serial_port_props.sv
// Checker for the serial result port pins
`timescale 1ns/1ps
module adsrp_serial_port_props
    import adsrp_pkg::*;
#(
    parameter int CONV_CYCLES = 40000
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins and status
    input wire logic cs_n,
    input wire logic sck_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic conv_busy,
    input wire logic sck_master
);
    int busy_cnt;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Length of the current conversion
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_cnt <= 0;
        else
            busy_cnt <= conv_busy ? busy_cnt + 1 : 0;
    end
    property p_oe_off;
        cs_n [*5] |-> !sdo_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
    property p_oe_on;
        !cs_n [*6] |-> sdo_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("sdo undriven while selected");
    property p_busy_hi;
        sdo_oe && conv_busy && $past(conv_busy, 3) && $past(sdo_oe, 3) |-> sdo_out;
    endproperty
    a_busy_hi: assert property (p_busy_hi) else $error("indicator low while busy");
    property p_eoc_fall;
        $fell(conv_busy) && sdo_oe |-> ##[0:3] !sdo_out;
    endproperty
    a_eoc_fall: assert property (p_eoc_fall) else $error("indicator did not fall");
    property p_sck_ign;
        !conv_busy && cs_n && $past(cs_n, 6) |=> !conv_busy;
    endproperty
    a_sck_ign: assert property (p_sck_ign) else $error("start while deselected");
    property p_conv_start;
        $rose(conv_busy) |-> !$past(cs_n, 6);
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("start without frame");
    property p_conv_len;
        $fell(conv_busy) |-> busy_cnt >= CONV_CYCLES - 2 && busy_cnt <= CONV_CYCLES + 2;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_master_oe;
        sck_oe |-> sck_master;
    endproperty
    a_master_oe: assert property (p_master_oe) else $error("clock driven in slave mode");
    property p_sck_oe_cs;
        cs_n [*6] |-> !sck_oe;
    endproperty
    a_sck_oe_cs: assert property (p_sck_oe_cs) else $error("clock driven idle");
    c_frame: cover property ($rose(conv_busy) && !cs_n);
    c_abort: cover property ($rose(conv_busy) && cs_n);
    c_ready: cover property ($fell(conv_busy) && sdo_oe);
    c_master: cover property ($fell(conv_busy) && sck_master && sdo_oe);
endmodule

bind adsrp_serial_port adsrp_serial_port_props #(.CONV_CYCLES(CONV_CYCLES)) i_props (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sck_oe(sck_oe),
    .sdo_out(sdo_out),
    .sdo_oe(sdo_oe),
    .conv_busy(conv_busy),
    .sck_master(sck_master)
);

// File: tb/adsrp_host_model.sv
// Host model driving the serial pins with an external clock, or listening on the device clock
`timescale 1ns/1ps
module adsrp_host_model (
    // Clock
    input wire logic sys_clk,
    // Pins
    output logic cs_n,
    output logic sck_drv,
    output logic sck_en,
    output logic sdi,
    input wire logic sck,
    input wire logic sdo
);
    // Clock floats until first select
    initial
    begin
        cs_n = 1'b1;
        sck_drv = 1'b0;
        sck_en = 1'b0;
        sdi = 1'b0;
    end
    // Select; ext holds the clock low, otherwise the clock floats
    task automatic pin_cs(input logic v, input logic ext);
        sck_en <= ext;
        cs_n <= v;
        repeat (10) @(posedge sys_clk);
    endtask
    // Result bits in on the rises of the device clock, setup input low
    task automatic listen(output logic [31:0] q);
        q = '0;
        sdi <= 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge sck);
            q[31 - i] = sdo;
        end
        repeat (30) @(posedge sys_clk);
    endtask
    // Setup bits out, result bits in on rises
    task automatic pulses(input int n, input logic [12:0] din, output logic [31:0] q);
        q = '0;
        for (int i = 0; i < n; i++)
        begin
            sck_drv <= 1'b0;
            sdi <= (i < 13) ? din[12 - i] : ~sdi;
            repeat (20) @(posedge sys_clk);
            q[31 - i] = sdo;
            sck_drv <= 1'b1;
            repeat (20) @(posedge sys_clk);
        end
        sck_drv <= 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask
endmodule

// File: tb/adsrp_serial_port_tb_top.sv
// Self-checking bench for the serial result port
`timescale 1ns/1ps
module adsrp_serial_port_tb_top;
    import adsrp_pkg::*;
    localparam int CONV = 200;
    logic sys_clk, rst_n, cs_n, sck_drv, sck_en, sdi, sck_out, sck_oe, sdo_out, sdo_oe;
    logic conv_busy, sck_master, sck_wire, sdo_wire;
    logic sdo_hold = 1'b0;
    logic signed [31:0] conv_sample;
    logic signed [31:0] corner [5] = '{CODE_OVER + 32'sd7, CODE_UNDER - 32'sd3, 32'sd0,
        -32'sd1, 32'sh0fff_ffe0};
    logic [2:0] pre [3] = '{3'h0, 3'h4, 3'h5};
    adsrp_cfg_t active_cfg, exp_cfg;
    logic [31:0] q;
    logic [12:0] din;
    int err_count, checked, seed;
    int sck_rises, base;
    logic mst;

    // Wire levels: pull-up on clock, released data inverted
    assign sck_wire = sck_oe ? sck_out : (sck_en ? sck_drv : 1'b1);
    assign sdo_wire = sdo_oe ? sdo_out : ~sdo_hold;
    always @(posedge sys_clk)
        if (sdo_oe)
            sdo_hold <= sdo_out;
    always @(posedge sck_wire)
        if (sck_oe)
            sck_rises++;

    adsrp_serial_port #(.CONV_CYCLES(CONV)) i_dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .sck_in(sck_wire),
        .sck_out(sck_out),
        .sck_oe(sck_oe),
        .sdi(sdi),
        .sdo_out(sdo_out),
        .sdo_oe(sdo_oe),
        .conv_sample(conv_sample),
        .conv_busy(conv_busy),
        .sck_master(sck_master),
        .active_cfg(active_cfg)
    );

    adsrp_host_model i_host (
        .sys_clk(sys_clk),
        .cs_n(cs_n),
        .sck_drv(sck_drv),
        .sck_en(sck_en),
        .sdi(sdi),
        .sck(sck_wire),
        .sdo(sdo_wire)
    );

    function automatic logic [31:0] exp_frame(input logic signed [31:0] s);
        logic signed [31:0] c;
        c = (s > CODE_OVER) ? CODE_OVER : ((s < CODE_UNDER) ? CODE_UNDER : s);
        return {2'b00, ~c[31], c[28:0]};
    endfunction

    function automatic adsrp_cfg_t next_cfg(input adsrp_cfg_t old, input logic [12:0] d);
        next_cfg = old;
        if (d[12:10] == PREFIX_LOAD)
        begin
            next_cfg.sel = d[9:5];
            if (d[4])
                next_cfg.mode = d[3:0];
        end
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wait_done();
        for (int i = 0; i < 1000 && conv_busy !== 1'b0; i++)
            @(posedge sys_clk);
        if (conv_busy !== 1'b0)
        begin
            err_count++;
            $display("[ERR] %0t conversion did not end", $time);
        end
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic summarize();
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        summarize();
    end

    initial
    begin
        seed = 32'hf0e7;
        err_count = 0;
        checked = 0;
        rst_n = 1'b0;
        conv_sample = CODE_OVER + 32'sd9;
        exp_cfg = '0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(sck_master, 1'b1);
        for (int i = 0; i < 9; i++)
        begin
            mst = (i % 4) == 3;
            i_host.pin_cs(1'b0, !mst);
            chk({sdo_oe, sdo_out, sck_master}, {2'b11, mst});
            wait_done();
            chk({sdo_oe, sdo_out}, 2'b10);
            din = mst ? 13'h0 : {pre[i % 3], 10'($random(seed))};
            base = sck_rises;
            if (mst)
                i_host.listen(q);
            else
                i_host.pulses(32, din, q);
            chk(q, exp_frame(conv_sample));
            chk({sdo_out, conv_busy}, 2'b11);
            chk(sck_rises - base, mst ? 32 : 0);
            exp_cfg = next_cfg(exp_cfg, din);
            chk({23'h0, active_cfg}, {23'h0, exp_cfg});
            conv_sample <= (i < 5) ? corner[i] : ($random(seed) >>> 3);
            i_host.pin_cs(1'b1, !mst);
            chk(sdo_oe, 1'b0);
        end
        wait_done();
        i_host.pulses(4, 13'h1fff, q);
        i_host.pin_cs(1'b0, 1'b1);
        i_host.pin_cs(1'b1, 1'b1);
        chk({conv_busy, sdo_oe}, 2'b00);
        i_host.pin_cs(1'b0, 1'b1);
        chk(sdo_out, 1'b0);
        i_host.pulses(5, 13'h1fff, q);
        i_host.pin_cs(1'b1, 1'b1);
        chk(conv_busy, 1'b1);
        summarize();
    end
endmodule
